// *** logic/tag_mode_config_control.sv ***
// configuration decode, mode select and pass-through receive path
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - priority bit 0: eeprom first come first served
// - priority bit 1: radio wins when both ask for a free eeprom
// - i2c address is 1010b plus three bits
// - keep-crc bit stores crc, 32 byte limit
// - crc always checked on received frames
// - regulator level and resistance fields driven out
// - rf config allow off blocks last two blocks
// - mode bits copied to volatile at init
// - authenticated rf may change auth settings if allowed
// - authenticated rf may always change password; code refuses it in pass-through
// - invert select reply bit6 on level two
// - two-bit power mode decoded to four modes
// - mask defaults loaded into mask registers
// - both modes enabled means pass-through
// - no mode: eeprom serves selected radio commands
// - pass-through blocks rf eeprom, buffers frames
// - pass-through raises receive, transmit, error events
// - host reply command sent on radio
// - pass-through keeps host eeprom access open
// - mailbox maps FCh-FFh to host buffer
// - mailbox drops bad frames, acks good writes
// - kill bit7 disables both special modes
module tag_mode_config_control
  import tag_mode_pkg::*; #(
  parameter int BLOCKS = EE_BLOCKS,
  parameter int DEPTH  = 4
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire cfg_wr_s    cfgWr,
  input  wire logic       initLoad,
  input  wire logic       rfClkPin,
  input  wire logic       rfDataPin,
  input  wire logic       rfFramePin,
  input  wire logic       tagSelected,
  input  wire logic       cascadeLevel2,
  input  wire logic [7:0] selReplyByte,
  input  wire logic       authenticated,
  input  wire rf_req_s    rfReq,
  input  wire logic       hostEeReq,
  input  wire host_cmd_s  hostCmd,
  input  wire logic       rfTxReady,
  input  wire logic       txDoneEvt,
  input  wire logic       parityErrEvt,
  input  wire logic       framingErrEvt,
  input  wire logic       hostBufAccessErr,
  input  wire logic       bufReady,
  output var  logic [7:0] bufData,
  output var  logic       bufValid,
  output var  logic [6:0] i2cAddress,
  output var  logic [4:0] regulatedSupplyLevel,
  output var  logic [1:0] regulatedSupplyResistance,
  output var  logic [7:0] selReplyOut,
  output var  logic       powerRfOnly,
  output var  logic       powerCompanion,
  output var  logic       powerExternal,
  output var  mode_e      activeMode,
  output var  logic [7:0] irqMask0,
  output var  logic [7:0] irqMask1,
  output var  logic       rfEeGrant,
  output var  logic       hostEeGrant,
  output var  logic       rfReqDenied,
  output var  logic       rfToMailbox,
  output var  logic       evRxStart,
  output var  logic       evRxEnd,
  output var  logic       evTxEnd,
  output var  logic       crcErrIrq,
  output var  logic       parityErrIrq,
  output var  logic       framingErrIrq,
  output var  logic       bufferErrorIrq,
  output var  logic       accessErrIrq,
  output var  logic       mailboxAck,
  output var  logic       mailboxDiscard,
  output var  logic       replyReq,
  output var  host_cmd_s  replyCmd,
  output var  logic       tagStateReq,
  output var  host_cmd_e  tagStateCmd
);
  initial begin
    if (BLOCKS < PROTECTED_TOP + 1 || BLOCKS > 256 || DEPTH < 2)
      $error("tag_mode_config_control: bad parameter");
  end

  localparam logic [7:0] FIRST_GUARDED = 8'(BLOCKS - PROTECTED_TOP);
  localparam logic [5:0] BUF_LIMIT     = 6'(BUF_BYTES);

  typedef enum logic [1:0] {RX_IDLE, RX_BUSY, RX_FLUSH} rx_e;

  typedef struct packed {
    logic [2:0]  clkSync;
    logic [1:0]  datSync;
    logic [2:0]  frmSync;
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  kill;
    logic [7:0]  mask0Def;
    logic [7:0]  mask1Def;
    logic        passVol;
    logic        mboxVol;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    mode_e       mode;
    rx_e         rx;
    logic        storeFrame;
    logic [15:0] crc;
    logic [2:0]  bitCnt;
    logic [7:0]  shift;
    logic [1:0]  holdCnt;
    logic [7:0]  hold0;
    logic [7:0]  hold1;
    logic [5:0]  stored;
    logic        outValid;
    logic [7:0]  outByte;
    logic [6:0]  i2cAddr;
    logic [4:0]  vreg;
    logic [1:0]  rreg;
    logic [7:0]  selOut;
    logic [2:0]  pow;
    logic        denied;
    logic        toMbox;
    logic [9:0]  ev;
    logic        replyPend;
    host_cmd_s   reply;
    logic        stateReq;
    host_cmd_e   stateCmd;
  } top_s;

  top_s st, next_st;
  logic fifoInReady;
  logic rfEeWant;
  logic bitEdge;
  logic frameRise;
  logic frameFall;
  logic byteDone;
  logic [7:0] newByte;
  logic fb;
  logic emitOk;
  logic crcBad;
  logic inPass;
  logic inMbox;
  mode_e cfgMode;

  always_comb begin
    next_st = st;
    next_st.ev = '0;
    next_st.stateReq = 1'b0;
    next_st.denied = 1'b0;
    next_st.toMbox = 1'b0;
    newByte = {st.datSync[1], st.shift[7:1]};
    fb = 1'b0;
    byteDone = 1'b0;
    crcBad = 1'b0;

    // pins pass two flops; edges use only the later stages
    next_st.clkSync = {st.clkSync[1:0], rfClkPin};
    next_st.datSync = {st.datSync[0], rfDataPin};
    next_st.frmSync = {st.frmSync[1:0], rfFramePin};
    bitEdge   = st.clkSync[1] && !st.clkSync[2];
    frameRise = st.frmSync[1] && !st.frmSync[2];
    frameFall = !st.frmSync[1] && st.frmSync[2];

    if (cfgWr.valid) begin
      case (cfgWr.sel)
        SEL_CFG0:     next_st.cfg0 = cfgWr.data;
        SEL_CFG1:     next_st.cfg1 = cfgWr.data;
        SEL_CFG2:     next_st.cfg2 = cfgWr.data;
        SEL_KILL:     next_st.kill = cfgWr.data;
        SEL_MASK0DEF: next_st.mask0Def = cfgWr.data;
        SEL_MASK1DEF: next_st.mask1Def = cfgWr.data;
        SEL_MODEVOL: begin
          next_st.passVol = cfgWr.data[CFG2_PASS];
          next_st.mboxVol = cfgWr.data[CFG2_MBOX];
        end
        SEL_MASK0:    next_st.mask0 = cfgWr.data;
        SEL_MASK1:    next_st.mask1 = cfgWr.data;
        default:      next_st.cfg0 = st.cfg0;
      endcase
    end
    if (initLoad) begin
      next_st.passVol = st.cfg2[CFG2_PASS];
      next_st.mboxVol = st.cfg2[CFG2_MBOX];
      next_st.mask0 = st.mask0Def;
      next_st.mask1 = st.mask1Def;
    end

    if (st.kill[KILL_MODES]) cfgMode = MODE_STANDALONE;
    else if (st.passVol) cfgMode = MODE_PASS;
    else if (st.mboxVol) cfgMode = MODE_MAILBOX;
    else cfgMode = MODE_STANDALONE;
    inPass = (st.mode == MODE_PASS) && tagSelected;
    inMbox = (st.mode == MODE_MAILBOX) && tagSelected;

    next_st.i2cAddr = {I2C_GROUP, st.cfg0[CFG0_ADDR_HI:0]};
    next_st.vreg = st.cfg1[VREG_HI:VREG_LO];
    next_st.rreg = st.cfg1[RREG_HI:RREG_LO];
    next_st.selOut = selReplyByte;
    if (st.cfg2[CFG2_SELINV] && cascadeLevel2)
      next_st.selOut = selReplyByte ^ SEL_B6_MASK;
    case (st.cfg2[CFG2_POW_HI:0])
      POW_DEFAULT:   next_st.pow = 3'h0;
      POW_RF_ONLY:   next_st.pow = 3'h1;
      POW_COMPANION: next_st.pow = 3'h2;
      POW_EXTERNAL:  next_st.pow = 3'h4;
      default:       next_st.pow = 3'h0;
    endcase

    // radio memory request routing
    rfEeWant = 1'b0;
    if (rfReq.valid) begin
      if (inPass) begin
        next_st.denied = 1'b1;
      end else if (inMbox && rfReq.addr >= MBOX_FIRST) begin
        // top four blocks reach the buffer
        next_st.toMbox = 1'b1;
      end else if (rfReq.write && rfReq.kind == WR_PASSWORD) begin
        next_st.denied = !authenticated;
        rfEeWant = authenticated;
      end else if (rfReq.write && rfReq.kind == WR_AUTHCFG) begin
        next_st.denied = !(authenticated && st.cfg2[CFG2_AUTHSET]);
        rfEeWant = authenticated && st.cfg2[CFG2_AUTHSET];
      end else if (rfReq.write && !st.cfg2[CFG2_RFCFG]
                   && rfReq.addr >= FIRST_GUARDED) begin
        next_st.denied = 1'b1;
      end else begin
        rfEeWant = 1'b1;
      end
    end

    if (st.replyPend && rfTxReady) next_st.replyPend = 1'b0;
    // host reply held until the radio side is ready
    if (hostCmd.valid && inPass) begin
      case (hostCmd.cmd)
        CMD_ACK, CMD_NACK, CMD_TXBUF: begin
          next_st.replyPend = 1'b1;
          next_st.reply = hostCmd;
        end
        default: begin
          // sleep and sense commands forwarded as a tag state request
          next_st.stateReq = 1'b1;
          next_st.stateCmd = hostCmd.cmd;
        end
      endcase
    end

    // staging slot drains into the fifo
    emitOk = !st.outValid || fifoInReady;
    if (st.outValid && fifoInReady) next_st.outValid = 1'b0;

    // crc runs on every frame bit
    if (st.rx == RX_BUSY && bitEdge) begin
      fb = st.crc[0] ^ st.datSync[1];
      next_st.crc = {1'b0, st.crc[15:1]} ^ (fb ? CRC_POLY : 16'h0000);
      next_st.shift = newByte;
      next_st.bitCnt = st.bitCnt + 3'h1;
      byteDone = (st.bitCnt == 3'h7);
    end

    // two-byte delay lets the crc bytes be dropped or kept
    if (byteDone && st.storeFrame) begin
      if (st.holdCnt != 2'h2) begin
        next_st.holdCnt = st.holdCnt + 2'h1;
        if (st.holdCnt == 2'h0) next_st.hold0 = newByte;
        else next_st.hold1 = newByte;
      end else if (!emitOk || st.stored == BUF_LIMIT) begin
        next_st.ev[6] = 1'b1;
      end else begin
        next_st.outValid = 1'b1;
        next_st.outByte = st.hold0;
        next_st.stored = st.stored + 6'h1;
        next_st.hold0 = st.hold1;
        next_st.hold1 = newByte;
      end
    end

    case (st.rx)
      RX_IDLE: begin
        if (frameRise) begin
          next_st.mode = cfgMode;
          next_st.rx = RX_BUSY;
          next_st.crc = CRC_INIT;
          next_st.bitCnt = 3'h0;
          next_st.holdCnt = 2'h0;
          next_st.stored = 6'h0;
          next_st.storeFrame = (cfgMode == MODE_PASS) && tagSelected;
          next_st.ev[0] = (cfgMode == MODE_PASS) && tagSelected;
        end else begin
          next_st.mode = cfgMode;
        end
      end
      RX_BUSY: begin
        if (frameFall) begin
          crcBad = (st.crc != CRC_GOOD);
          next_st.ev[3] = crcBad && inPass;
          next_st.ev[1] = inPass;
          // mailbox answers clean writes, drops bad ones
          next_st.ev[8] = inMbox && !crcBad;
          next_st.ev[9] = inMbox && crcBad;
          if (st.cfg1[CFG1_KEEPCRC] && st.storeFrame && !crcBad)
            next_st.rx = RX_FLUSH;
          else
            next_st.rx = RX_IDLE;
        end
      end
      RX_FLUSH: begin
        if (st.holdCnt == 2'h0) begin
          next_st.rx = RX_IDLE;
        end else if (emitOk) begin
          if (st.stored == BUF_LIMIT) begin
            next_st.ev[6] = 1'b1;
            next_st.holdCnt = 2'h0;
          end else begin
            next_st.outValid = 1'b1;
            next_st.outByte = st.hold0;
            next_st.stored = st.stored + 6'h1;
            next_st.hold0 = st.hold1;
            next_st.holdCnt = st.holdCnt - 2'h1;
          end
        end
      end
      default: next_st.rx = RX_IDLE;
    endcase

    next_st.ev[2] = txDoneEvt && inPass;
    next_st.ev[4] = parityErrEvt && inPass;
    next_st.ev[5] = framingErrEvt && inPass;
    next_st.ev[7] = hostBufAccessErr && inPass;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.cfg0 <= CFG0_RESET;
      st.cfg1 <= CFG1_RESET;
      st.cfg2 <= CFG2_RESET;
      st.kill <= KILL_RESET;
      st.mask0Def <= MASK_RESET;
      st.mask1Def <= MASK_RESET;
      st.mask0 <= MASK_RESET;
      st.mask1 <= MASK_RESET;
      st.mode <= MODE_STANDALONE;
      st.rx <= RX_IDLE;
      st.crc <= CRC_INIT;
      st.i2cAddr <= {I2C_GROUP, 3'h0};
      st.reply.cmd <= CMD_ACK;
      st.stateCmd <= CMD_SLEEP;
    end else if (ce) begin
      st <= next_st;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .inValid  (st.outValid),
    .inReady  (fifoInReady),
    .inData   (st.outByte),
    .outValid (bufValid),
    .outReady (bufReady),
    .outData  (bufData)
  );

  // host side never blocked by pass-through traffic
  ee_arbiter arbiter (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .rfPriority (st.cfg0[CFG0_ARBIT]),
    .rfReq      (rfEeWant),
    .hostReq    (hostEeReq),
    .rfGrant    (rfEeGrant),
    .hostGrant  (hostEeGrant)
  );

  assign i2cAddress                = st.i2cAddr;
  assign regulatedSupplyLevel      = st.vreg;
  assign regulatedSupplyResistance = st.rreg;
  assign selReplyOut               = st.selOut;
  assign powerRfOnly               = st.pow[0];
  assign powerCompanion            = st.pow[1];
  assign powerExternal             = st.pow[2];
  assign activeMode                = st.mode;
  assign irqMask0                  = st.mask0;
  assign irqMask1                  = st.mask1;
  assign rfReqDenied               = st.denied;
  assign rfToMailbox               = st.toMbox;
  assign evRxStart                 = st.ev[0];
  assign evRxEnd                   = st.ev[1];
  assign evTxEnd                   = st.ev[2];
  assign crcErrIrq                 = st.ev[3];
  assign parityErrIrq              = st.ev[4];
  assign framingErrIrq             = st.ev[5];
  assign bufferErrorIrq            = st.ev[6];
  assign accessErrIrq              = st.ev[7];
  assign mailboxAck                = st.ev[8];
  assign mailboxDiscard            = st.ev[9];
  assign replyReq                  = st.replyPend;
  assign replyCmd                  = st.reply;
  assign tagStateReq               = st.stateReq;
  assign tagStateCmd               = st.stateCmd;
endmodule
`default_nettype wire

// *** logic/tag_mode_pkg.sv ***
// shared constants, enums and structs for the tag mode control block
package tag_mode_pkg;
  localparam logic [3:0]  I2C_GROUP     = 4'hA;
  localparam int          CFG1_KEEPCRC  = 7;
  localparam int          VREG_HI       = 6;
  localparam int          VREG_LO       = 2;
  localparam int          RREG_HI       = 1;
  localparam int          RREG_LO       = 0;
  localparam int          CFG0_ARBIT    = 3;
  localparam int          CFG0_ADDR_HI  = 2;
  localparam int          CFG2_RFCFG    = 7;
  localparam int          CFG2_PASS     = 6;
  localparam int          CFG2_MBOX     = 5;
  localparam int          CFG2_AUTHSET  = 3;
  localparam int          CFG2_SELINV   = 2;
  localparam int          CFG2_POW_HI   = 1;
  localparam int          KILL_MODES    = 7;
  localparam logic [7:0]  CFG0_RESET    = 8'h00;
  localparam logic [7:0]  CFG1_RESET    = 8'h00;
  localparam logic [7:0]  CFG2_RESET    = 8'h80;
  localparam logic [7:0]  KILL_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  SEL_B6_MASK   = 8'h40;
  localparam logic [7:0]  MBOX_FIRST    = 8'hFC;
  localparam logic [15:0] CRC_INIT      = 16'h6363;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_GOOD      = 16'h0000;
  localparam int          BUF_BYTES     = 32;
  localparam int          EE_BLOCKS     = 128;
  localparam int          PROTECTED_TOP = 2;
  localparam logic [1:0]  POW_DEFAULT   = 2'h0;
  localparam logic [1:0]  POW_RF_ONLY   = 2'h1;
  localparam logic [1:0]  POW_COMPANION = 2'h2;
  localparam logic [1:0]  POW_EXTERNAL  = 2'h3;

  typedef enum logic [1:0] {MODE_STANDALONE, MODE_PASS, MODE_MAILBOX} mode_e;
  typedef enum logic [3:0] {SEL_CFG0, SEL_CFG1, SEL_CFG2, SEL_KILL,
                            SEL_MASK0DEF, SEL_MASK1DEF, SEL_MODEVOL,
                            SEL_MASK0, SEL_MASK1} cfg_sel_e;
  typedef enum logic [2:0] {CMD_ACK, CMD_NACK, CMD_TXBUF, CMD_SLEEP,
                            CMD_SENSE, CMD_SENSE_SLEEP} host_cmd_e;
  typedef enum logic [1:0] {WR_DATA, WR_AUTHCFG, WR_PASSWORD} rf_wr_e;

  typedef struct packed {
    logic     valid;
    cfg_sel_e sel;
    logic [7:0] data;
  } cfg_wr_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    rf_wr_e     kind;
    logic [7:0] addr;
  } rf_req_s;

  typedef struct packed {
    logic      valid;
    host_cmd_e cmd;
    logic [2:0] nackCode;
  } host_cmd_s;
endpackage

// *** logic/byte_fifo.sv ***
// shift-register fifo whose head and flags all come from flops
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic [WIDTH-1:0] outData
);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("byte_fifo: bad size");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [DEPTH-1:0]            full;
  } fifo_s;

  fifo_s st, next_st;
  logic pop, push;

  always_comb begin
    next_st = st;
    pop  = st.full[0] && outReady;
    push = inValid && !st.full[DEPTH-1];
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.slot[i] = st.slot[i+1];
        next_st.full[i] = st.full[i+1];
      end
      next_st.full[DEPTH-1] = 1'b0;
    end
    // new word lands in the lowest free slot after any shift
    if (push) begin
      for (int i = DEPTH - 1; i >= 0; i--) begin
        if (!next_st.full[i] && (i == 0 || next_st.full[i-1])) begin
          next_st.slot[i] = inData;
          next_st.full[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign outValid = st.full[0];
  assign outData  = st.slot[0];
  assign inReady  = !st.full[DEPTH-1];
endmodule
`default_nettype wire

// *** logic/ee_arbiter.sv ***
// two-party eeprom arbiter: arrival order or radio precedence
`timescale 1ns/1ps
`default_nettype none
module ee_arbiter (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic rfPriority,
  input  wire logic rfReq,
  input  wire logic hostReq,
  output var  logic rfGrant,
  output var  logic hostGrant
);
  typedef struct packed {
    logic rfGnt;
    logic hostGnt;
    logic rfSeen;
    logic hostSeen;
  } arb_s;

  arb_s st, next_st;

  always_comb begin
    next_st = st;
    next_st.rfSeen   = rfReq;
    next_st.hostSeen = hostReq;
    if (st.rfGnt && !rfReq) next_st.rfGnt = 1'b0;
    if (st.hostGnt && !hostReq) next_st.hostGnt = 1'b0;
    if (!next_st.rfGnt && !next_st.hostGnt) begin
      if (rfReq && hostReq) begin
        if (rfPriority) next_st.rfGnt = 1'b1;
        // earlier arrival wins; a tie goes to radio
        else if (st.hostSeen && !st.rfSeen) next_st.hostGnt = 1'b1;
        else next_st.rfGnt = 1'b1;
      end else begin
        next_st.rfGnt   = rfReq;
        next_st.hostGnt = hostReq;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rfGrant   = st.rfGnt;
  assign hostGrant = st.hostGnt;
endmodule
`default_nettype wire

// *** dv/tag_mode_config_control_sva.sv ***
// property checker for the tag mode control block
`timescale 1ns/1ps
`default_nettype none
module tag_mode_config_control_sva
  import tag_mode_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire cfg_wr_s    cfgWr,
  input wire rf_req_s    rfReq,
  input wire host_cmd_s  hostCmd,
  input wire logic       tagSelected,
  input wire logic [7:0] selReplyByte,
  input wire logic [6:0] i2cAddress,
  input wire logic [4:0] regulatedSupplyLevel,
  input wire logic [1:0] regulatedSupplyResistance,
  input wire logic [7:0] selReplyOut,
  input wire logic       powerRfOnly,
  input wire logic       powerCompanion,
  input wire logic       powerExternal,
  input wire mode_e      activeMode,
  input wire logic       rfReqDenied,
  input wire logic       replyReq,
  input wire logic       tagStateReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic passSel;
  assign passSel = tagSelected && activeMode == MODE_PASS;

  i2c_address_a: assert property (
    cfgWr.valid && ce && cfgWr.sel == SEL_CFG0 ##2 1
    |-> i2cAddress == {I2C_GROUP, $past(cfgWr.data[2:0], 2)})
    else $error("i2c address not group plus low bits");
  regulator_fields_a: assert property (
    cfgWr.valid && ce && cfgWr.sel == SEL_CFG1 ##2 1
    |-> {regulatedSupplyLevel, regulatedSupplyResistance}
        == $past(cfgWr.data[6:0], 2))
    else $error("regulator fields wrong");
  power_decode_a: assert property (
    cfgWr.valid && ce && cfgWr.sel == SEL_CFG2 ##2 1
    |-> $onehot0({powerExternal, powerCompanion, powerRfOnly})
        && powerExternal == &$past(cfgWr.data[1:0], 2)
        && powerRfOnly == ($past(cfgWr.data[1:0], 2) == POW_RF_ONLY))
    else $error("power mode decode wrong");
  sel_reply_a: assert property (
    !$past(srst) |-> (selReplyOut & ~SEL_B6_MASK)
                     == ($past(selReplyByte) & ~SEL_B6_MASK))
    else $error("select reply bits other than six changed");
  pass_deny_a: assert property (
    rfReq.valid && passSel |=> rfReqDenied)
    else $error("radio request not refused in pass-through");
  reply_fwd_a: assert property (
    hostCmd.valid && passSel
    && hostCmd.cmd inside {CMD_ACK, CMD_NACK, CMD_TXBUF} |=> replyReq)
    else $error("host reply not taken");
  state_fwd_a: assert property (
    hostCmd.valid && passSel
    && hostCmd.cmd inside {CMD_SLEEP, CMD_SENSE, CMD_SENSE_SLEEP}
    |=> tagStateReq)
    else $error("state command not forwarded");
  standalone_read_a: assert property (
    rfReq.valid && !rfReq.write && rfReq.kind == WR_DATA
    && activeMode == MODE_STANDALONE |=> !rfReqDenied)
    else $error("standalone read refused");

  cover property (rfReqDenied);
  cover property (replyReq);
  cover property (activeMode == MODE_MAILBOX);
endmodule
bind tag_mode_config_control tag_mode_config_control_sva chk (.*);
`default_nettype wire

// *** dv/host_sink.sv ***
// host side model: drains the receive fifo, may stall
`timescale 1ns/1ps
`default_nettype none
module host_sink (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       bufValid,
  input  wire logic [7:0] bufData,
  output var  logic       bufReady
);
  logic [7:0] got [$];
  assign bufReady = !stall;
  always @(posedge clk)
    if (bufValid && bufReady)
      got.push_back(bufData);
endmodule
`default_nettype wire

// *** dv/tag_mode_config_control_test.sv ***
// self-checking bench for the tag mode control block
`timescale 1ns/1ps
`default_nettype none
module tag_mode_config_control_test
  import tag_mode_pkg::*;
;
  logic clk = 0, srst = 1, ce = 1, initLoad = 0, stall = 1;
  logic rfClkPin = 0, rfDataPin = 0, rfFramePin = 0, tagSelected = 1;
  logic cascadeLevel2 = 0, authenticated = 0, hostEeReq = 0;
  logic rfTxReady = 0, txDoneEvt = 0, parityErrEvt = 0;
  logic framingErrEvt = 0, hostBufAccessErr = 0;
  logic [7:0] selReplyByte = 8'h81, hits = 8'h00;
  cfg_wr_s cfgWr = '0;
  rf_req_s rfReq = '0;
  host_cmd_s hostCmd = '0;
  logic bufReady, bufValid, powerRfOnly, powerCompanion, powerExternal;
  logic rfEeGrant, hostEeGrant, rfReqDenied, rfToMailbox, evRxStart;
  logic evRxEnd, evTxEnd, crcErrIrq, parityErrIrq, framingErrIrq;
  logic bufferErrorIrq, accessErrIrq, mailboxAck, mailboxDiscard;
  logic replyReq, tagStateReq;
  logic [7:0] bufData, selReplyOut, irqMask0, irqMask1;
  logic [6:0] i2cAddress;
  logic [4:0] regulatedSupplyLevel;
  logic [1:0] regulatedSupplyResistance;
  mode_e activeMode;
  host_cmd_s replyCmd;
  host_cmd_e tagStateCmd;
  int failures = 0, cmp_count = 0;

  tag_mode_config_control uut (.*);
  host_sink host (.clk, .stall, .bufValid, .bufData, .bufReady);

  always #2.5 clk = ~clk;
  // pulses are collected so their exact cycle does not matter
  always @(posedge clk)
    hits <= hits | {rfReqDenied, rfToMailbox, rfEeGrant, hostEeGrant,
                    replyReq, tagStateReq, evRxEnd, crcErrIrq};

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task cw(input cfg_sel_e s, input logic [7:0] d);
    @(posedge clk) cfgWr <= '{1'b1, s, d};
    @(posedge clk) cfgWr.valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task rq(input logic w, input rf_wr_e k, input logic [7:0] a,
          input logic [7:0] e);
    #1 hits = 8'h00;
    @(posedge clk) rfReq <= '{1'b1, w, k, a};
    repeat (4) @(posedge clk);
    rfReq.valid <= 1'b0;
    @(posedge clk) #1 chk(hits, e);
  endtask

  task ar(input int lead, input logic [7:0] e);
    #1 hits = 8'h00;
    @(posedge clk) hostEeReq <= 1'b1;
    repeat (lead) @(posedge clk);
    rfReq <= '{1'b1, 1'b0, WR_DATA, 8'h10};
    repeat (4) @(posedge clk);
    hostEeReq <= 1'b0;
    rfReq.valid <= 1'b0;
    @(posedge clk) #1 chk(hits, e);
  endtask

  task hc(input host_cmd_e c, input logic [7:0] e);
    #1 hits = 8'h00;
    @(posedge clk) hostCmd <= '{1'b1, c, 3'h5};
    @(posedge clk) hostCmd.valid <= 1'b0;
    repeat (2) @(posedge clk);
    rfTxReady <= 1'b1;
    @(posedge clk) rfTxReady <= 1'b0;
    #1 chk(hits, e);
  endtask

  task automatic fr(input logic bad);
    logic [7:0] b [5];
    logic [15:0] c;
    c = 16'h6363;
    b = '{8'hA1, 8'hB2, 8'hC3, 8'h00, 8'h00};
    for (int i = 0; i < 24; i++)
      c = (c >> 1) ^ ((c[0] ^ b[i/8][i%8]) ? 16'h8408 : 16'h0000);
    b[3] = c[7:0];
    b[4] = c[15:8] ^ {7'h00, bad};
    #1 hits = 8'h00;
    @(posedge clk) rfFramePin <= 1'b1;
    // link clock idles low between frames, lsb first
    for (int i = 0; i < 40; i++) begin
      rfDataPin <= b[i/8][i%8];
      #32 rfClkPin <= 1'b1;
      #32 rfClkPin <= 1'b0;
    end
    @(posedge clk) rfFramePin <= 1'b0;
    repeat (20) @(posedge clk);
    stall <= 1'b0;
    repeat (10) @(posedge clk);
    stall <= 1'b1;
    #1 chk(hits, {6'h00, 1'b1, bad});
    for (int i = 0; i < 5 - 2 * bad; i++)
      chk(host.got[host.got.size() - 5 + 2 * bad + i], b[i]);
  endtask

  initial begin
    #400000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) #1;
    chk({1'b0, i2cAddress}, 8'h50);
    chk({6'h00, activeMode}, {6'h00, MODE_STANDALONE});
    $display("reset test done");
    cw(SEL_CFG0, 8'h0D);
    chk({1'b0, i2cAddress}, 8'h55);
    cw(SEL_CFG1, 8'hFE);
    chk({1'b0, regulatedSupplyLevel, regulatedSupplyResistance}, 8'h7E);
    for (int i = 0; i < 4; i++) begin
      cw(SEL_CFG2, 8'(i));
      chk({5'h00, powerExternal, powerCompanion, powerRfOnly},
          (8'h01 << i) >> 1);
    end
    cw(SEL_CFG2, 8'h04);
    for (int j = 1; j >= 0; j--) begin
      @(posedge clk) cascadeLevel2 <= j[0];
      repeat (2) @(posedge clk);
      #1 chk(selReplyOut, {1'b1, j[0], 6'h01});
    end
    $display("config test done");
    cw(SEL_MASK0DEF, 8'h5A);
    cw(SEL_CFG2, 8'h60);
    @(posedge clk) initLoad <= 1'b1;
    @(posedge clk) initLoad <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(irqMask0, 8'h5A);
    chk({6'h00, activeMode}, {6'h00, MODE_PASS});
    rq(1'b1, WR_DATA, 8'h10, 8'h80);
    ar(0, 8'h90);
    for (int k = 0; k < 6; k++)
      hc(host_cmd_e'(k), k < 3 ? 8'h08 : 8'h04);
    fr(1'b0);
    fr(1'b1);
    $display("pass-through test done");
    cw(SEL_MODEVOL, 8'h00);
    rq(1'b1, WR_DATA, 8'h7E, 8'h80);
    rq(1'b1, WR_DATA, 8'h7D, 8'h20);
    rq(1'b1, WR_PASSWORD, 8'h10, 8'h80);
    @(posedge clk) authenticated <= 1'b1;
    rq(1'b1, WR_PASSWORD, 8'h10, 8'h20);
    rq(1'b1, WR_AUTHCFG, 8'h10, 8'h80);
    cw(SEL_CFG2, 8'h08);
    rq(1'b1, WR_AUTHCFG, 8'h10, 8'h20);
    ar(0, 8'h20);
    cw(SEL_CFG0, 8'h00);
    ar(2, 8'h10);
    $display("standalone test done");
    cw(SEL_MODEVOL, 8'h20);
    chk({6'h00, activeMode}, {6'h00, MODE_MAILBOX});
    rq(1'b0, WR_DATA, 8'hFC, 8'h40);
    rq(1'b0, WR_DATA, 8'h10, 8'h20);
    cw(SEL_MODEVOL, 8'h60);
    chk({6'h00, activeMode}, {6'h00, MODE_PASS});
    cw(SEL_KILL, 8'h80);
    chk({6'h00, activeMode}, {6'h00, MODE_STANDALONE});
    $display("mode test done");
    end_of_test();
  end
endmodule
`default_nettype wire
